// ==== design/spmc_top.sv ====
// Purpose: sleep mode power controller, picks which clocks run per mode
// Assumes: serial and pin change wake pins are asynchronous, all other inputs on REF_CLK
// Notes: sleep is entered by a one cycle SLEEP_REQ with SLEEP_MODE
`timescale 1ns/1ps
`default_nettype none
module spmc_top
    import spmc_pkg::*;
#(
    parameter int NUM_PERIPH = SPMC_NUM_PERIPH
)(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SLEEP_REQ,
    input wire logic [SPMC_MODE_W-1:0] SLEEP_MODE,
    input wire logic [NUM_PERIPH-1:0] PERIPH_ON,
    input wire logic IRQ_WAKE,
    input wire logic RTC_WAKE,
    input wire logic TWO_WIRE_SERIAL_INTERFACE_WAKE,
    input wire logic PIN_CHANGE_WAKE,
    output logic CPU_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic XTAL_EN,
    output logic RTC_EN,
    output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN,
    output logic SLEEPING,
    output logic [SPMC_MODE_W-1:0] ACTIVE_MODE,
    output logic MODE_ERR
);
    if (NUM_PERIPH < 1 || NUM_PERIPH > SPMC_NUM_PERIPH)
    begin : g_bad_periph
        $error("NUM_PERIPH out of range");
    end

    spmc_gate_if gif();
    spmc_state_e state;
    spmc_state_e next_state;
    spmc_mode_e mode;
    spmc_mode_e next_mode;
    logic [7:0] wake_cnt;
    logic twi_s1, twi_s2, pin_s1, pin_s2;
    logic wake;
    logic mode_ok;

    // asynchronous wake pins
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            twi_s1 <= 1'b0;
            twi_s2 <= 1'b0;
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end
        else
        begin
            twi_s1 <= TWO_WIRE_SERIAL_INTERFACE_WAKE;
            twi_s2 <= twi_s1;
            pin_s1 <= PIN_CHANGE_WAKE;
            pin_s2 <= pin_s1;
        end
    end

    always_comb
    begin
        case (SLEEP_MODE)
            SPMC_IDLE, SPMC_PDOWN, SPMC_PSAVE, SPMC_STDBY, SPMC_ESTDBY:
                mode_ok = 1'b1;
            default:
                mode_ok = 1'b0;
        endcase
    end

    // wake sources allowed per mode
    always_comb
    begin
        case (mode)
            SPMC_IDLE:
                wake = IRQ_WAKE | RTC_WAKE | twi_s2 | pin_s2;
            SPMC_PSAVE, SPMC_ESTDBY:
                wake = RTC_WAKE | twi_s2 | pin_s2;
            default:
                wake = twi_s2 | pin_s2;
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            SPMC_ST_ACTIVE:
                if (SLEEP_REQ && mode_ok)
                    next_state = SPMC_ST_SLEEP;
            SPMC_ST_SLEEP:
                if (wake)
                    next_state = SPMC_ST_WAKE;
            SPMC_ST_WAKE:
                if (wake_cnt == 8'h00)
                    next_state = SPMC_ST_ACTIVE;
            default:
                next_state = SPMC_ST_ACTIVE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state <= SPMC_ST_ACTIVE;
        else
            state <= next_state;
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            mode <= SPMC_IDLE;
        else
            mode <= next_mode;
    end

    // mode being taken this cycle, so outputs can register it at once
    always_comb
    begin
        next_mode = mode;
        if (state == SPMC_ST_ACTIVE && SLEEP_REQ && mode_ok)
            next_mode = spmc_mode_e'(SLEEP_MODE);
    end

    // oscillator settle count on the way out of sleep
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            wake_cnt <= 8'h00;
        else if (state == SPMC_ST_SLEEP)
            wake_cnt <= 8'(SPMC_WAKE_CYCLES - 1);
        else if (wake_cnt != 8'h00)
            wake_cnt <= wake_cnt - 8'h01;
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            MODE_ERR <= 1'b0;
        else if (SLEEP_REQ && state == SPMC_ST_ACTIVE)
            MODE_ERR <= !mode_ok;
    end

    // decided on next state so enables register with SLEEPING
    // wake state restarts all clocks but the cpu
    always_comb
    begin
        gif.cpu_run = (next_state == SPMC_ST_ACTIVE);
        gif.periph_run = 1'b1;
        gif.main_osc_run = 1'b1;
        gif.xtal_run = 1'b1;
        gif.rtc_run = 1'b1;
        if (next_state == SPMC_ST_SLEEP)
        begin
            case (next_mode)
                SPMC_IDLE:
                begin
                    gif.cpu_run = 1'b0;
                end
                SPMC_PDOWN:
                begin
                    gif.periph_run = 1'b0;
                    gif.main_osc_run = 1'b0;
                    gif.xtal_run = 1'b0;
                    gif.rtc_run = 1'b0;
                end
                SPMC_PSAVE:
                begin
                    gif.periph_run = 1'b0;
                    gif.main_osc_run = 1'b0;
                    gif.xtal_run = 1'b0;
                    gif.rtc_run = 1'b1;
                end
                SPMC_STDBY:
                begin
                    gif.periph_run = 1'b0;
                    gif.main_osc_run = 1'b0;
                    gif.xtal_run = 1'b1;
                    gif.rtc_run = 1'b0;
                end
                SPMC_ESTDBY:
                begin
                    gif.periph_run = 1'b0;
                    gif.main_osc_run = 1'b1;
                    gif.xtal_run = 1'b0;
                    gif.rtc_run = 1'b1;
                end
                default:
                begin
                    gif.cpu_run = 1'b0;
                end
            endcase
        end
    end

    spmc_gate #(
        .NUM_PERIPH(NUM_PERIPH)
    ) u_gate (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .g(gif.gate),
        .periph_on(PERIPH_ON),
        .cpu_en(CPU_CLK_EN),
        .main_osc_en(MAIN_OSC_EN),
        .xtal_en(XTAL_EN),
        .rtc_en(RTC_EN),
        .periph_en(PERIPH_CLK_EN)
    );

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SLEEPING <= 1'b0;
            ACTIVE_MODE <= SPMC_IDLE;
        end
        else
        begin
            SLEEPING <= (next_state != SPMC_ST_ACTIVE);
            ACTIVE_MODE <= next_mode;
        end
    end
endmodule
`default_nettype wire

// ==== design/spmc_pkg.sv ====
// Purpose: shared constants and types for the sleep mode power controller
// Assumes: one 20 MHz reference clock
// Notes: mode codes are held in a three bit field
package spmc_pkg;

    localparam int SPMC_MODE_W = 3;
    localparam int SPMC_NUM_PERIPH = 8;
    localparam int SPMC_CLK_MHZ = 20;
    // oscillator restart settle time, in ns
    localparam int SPMC_WAKE_SETTLE_NS = 200;
    localparam int SPMC_WAKE_CYCLES =
        (SPMC_WAKE_SETTLE_NS * SPMC_CLK_MHZ + 999) / 1000;
    localparam logic [SPMC_NUM_PERIPH-1:0] SPMC_PERIPH_RESET = 8'hFF;

    typedef enum logic [SPMC_MODE_W-1:0] {
        SPMC_IDLE = 3'h0,
        SPMC_PDOWN = 3'h2,
        SPMC_PSAVE = 3'h3,
        SPMC_STDBY = 3'h6,
        SPMC_ESTDBY = 3'h7
    } spmc_mode_e;

    typedef enum logic [1:0] {
        SPMC_ST_ACTIVE = 2'h0,
        SPMC_ST_SLEEP = 2'h1,
        SPMC_ST_WAKE = 2'h2
    } spmc_state_e;

endpackage

// ==== design/spmc_gate_if.sv ====
// Purpose: carries the clock gating decision to the gate module
// Assumes: single clock domain
// Notes: enables are active high
`timescale 1ns/1ps
`default_nettype none
interface spmc_gate_if;
    logic cpu_run;
    logic periph_run;
    logic main_osc_run;
    logic xtal_run;
    logic rtc_run;
    modport ctrl (output cpu_run, periph_run, main_osc_run, xtal_run,
                  rtc_run);
    modport gate (input cpu_run, periph_run, main_osc_run, xtal_run,
                  rtc_run);
endinterface
`default_nettype wire

// ==== design/spmc_gate.sv ====
// Purpose: registered clock enable outputs per function and peripheral
// Assumes: enables from the controller are synchronous to REF_CLK
// Notes: one enable per peripheral combines the global and local request
`timescale 1ns/1ps
`default_nettype none
module spmc_gate
    import spmc_pkg::*;
#(
    parameter int NUM_PERIPH = SPMC_NUM_PERIPH
)(
    input wire logic clk,
    input wire logic rst_n,
    spmc_gate_if.gate g,
    input wire logic [NUM_PERIPH-1:0] periph_on,
    output logic cpu_en,
    output logic main_osc_en,
    output logic xtal_en,
    output logic rtc_en,
    output logic [NUM_PERIPH-1:0] periph_en
);
    if (NUM_PERIPH < 1 || NUM_PERIPH > SPMC_NUM_PERIPH)
    begin : g_bad_periph
        $error("NUM_PERIPH out of range");
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_en <= 1'b1;
            main_osc_en <= 1'b1;
            xtal_en <= 1'b1;
            rtc_en <= 1'b1;
            periph_en <= SPMC_PERIPH_RESET[NUM_PERIPH-1:0];
        end
        else
        begin
            cpu_en <= g.cpu_run;
            main_osc_en <= g.main_osc_run;
            xtal_en <= g.xtal_run;
            rtc_en <= g.rtc_run;
            periph_en <= {NUM_PERIPH{g.periph_run}} & periph_on;
        end
    end
endmodule
`default_nettype wire

// ==== verif/spmc_properties.sv ====
// Purpose: port assertions for the sleep mode controller
// Assumes: one clock domain on REF_CLK
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module spmc_props
    import spmc_pkg::*;
#(
    parameter int NUM_PERIPH = SPMC_NUM_PERIPH
)(
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SLEEP_REQ,
    input wire logic [SPMC_MODE_W-1:0] SLEEP_MODE,
    input wire logic [NUM_PERIPH-1:0] PERIPH_ON,
    input wire logic PIN_CHANGE_WAKE,
    input wire logic CPU_CLK_EN,
    input wire logic MAIN_OSC_EN,
    input wire logic XTAL_EN,
    input wire logic RTC_EN,
    input wire logic [NUM_PERIPH-1:0] PERIPH_CLK_EN,
    input wire logic SLEEPING,
    input wire logic [SPMC_MODE_W-1:0] ACTIVE_MODE,
    input wire logic MODE_ERR
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic ok;
    assign ok = SLEEP_MODE inside {SPMC_IDLE, SPMC_PDOWN, SPMC_PSAVE,
        SPMC_STDBY, SPMC_ESTDBY};
    property p_enter;
        !SLEEPING && SLEEP_REQ && ok |=> SLEEPING && !CPU_CLK_EN;
    endproperty
    a_enter: assert property (p_enter)
        else $error("legal request did not sleep");
    property p_bad;
        !SLEEPING && SLEEP_REQ && !ok |=> MODE_ERR && !SLEEPING;
    endproperty
    a_bad: assert property (p_bad)
        else $error("illegal code not refused");
    property p_ign;
        SLEEPING && SLEEP_REQ |=> $stable(ACTIVE_MODE);
    endproperty
    a_ign: assert property (p_ign)
        else $error("request taken while asleep");
    property p_halt;
        SLEEPING |-> !CPU_CLK_EN;
    endproperty
    a_halt: assert property (p_halt)
        else $error("cpu clock runs while asleep");
    property p_periph;
        (!SLEEPING || ACTIVE_MODE == SPMC_IDLE) && $past(RST_N)
            && $past(SLEEPING) == SLEEPING
            |-> PERIPH_CLK_EN == $past(PERIPH_ON);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral enable not following request");
    property p_pdown;
        $rose(SLEEPING) && ACTIVE_MODE == SPMC_PDOWN
            |-> !(MAIN_OSC_EN || XTAL_EN || RTC_EN) && PERIPH_CLK_EN == '0;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down left a clock running");
    property p_keep;
        $rose(SLEEPING) |-> (ACTIVE_MODE != SPMC_PSAVE || RTC_EN)
            && (ACTIVE_MODE != SPMC_STDBY || XTAL_EN)
            && (ACTIVE_MODE != SPMC_ESTDBY || (MAIN_OSC_EN && RTC_EN));
    endproperty
    a_keep: assert property (p_keep)
        else $error("kept oscillator stopped");
    property p_wake;
        SLEEPING && $rose(PIN_CHANGE_WAKE)
            |-> ##[1:12] !SLEEPING && CPU_CLK_EN;
    endproperty
    a_wake: assert property (p_wake)
        else $error("pin change did not wake");
endmodule
`default_nettype wire

// ==== verif/sleep_mode_power_controller_tb.sv ====
// Purpose: directed bench for the sleep mode controller
// Assumes: 20 MHz clock, inputs driven 1 ns after the edge
// Notes: mode table holds expected oscillator enables
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_controller_tb;
    import spmc_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic req = 0;
    logic [2:0] mode = 3'h0;
    logic [7:0] pon = 8'hFF;
    logic irq = 0, rtc = 0, two_wire_serial_interface = 0, pin = 0;
    logic cpu, mosc, xtal, rtce, slp, err;
    logic [7:0] pen;
    logic [2:0] amode;
    int n_errors = 0, compares = 0, cyc = 0;
    always #25 clk = ~clk;
    spmc_top #(.NUM_PERIPH(8)) u_dut (.REF_CLK(clk), .RST_N(rst_n),
        .SLEEP_REQ(req), .SLEEP_MODE(mode), .PERIPH_ON(pon),
        .IRQ_WAKE(irq), .RTC_WAKE(rtc),
        .TWO_WIRE_SERIAL_INTERFACE_WAKE(two_wire_serial_interface), .PIN_CHANGE_WAKE(pin),
        .CPU_CLK_EN(cpu), .MAIN_OSC_EN(mosc), .XTAL_EN(xtal),
        .RTC_EN(rtce), .PERIPH_CLK_EN(pen), .SLEEPING(slp),
        .ACTIVE_MODE(amode), .MODE_ERR(err));
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sleep(input logic [2:0] m);
        req = 1;
        mode = m;
        step(1);
        req = 0;
        step(1);
    endtask
    // src bits: irq, rtc, serial, pin; held until awake
    task automatic wake(input logic [3:0] src);
        {irq, rtc, two_wire_serial_interface, pin} = src;
        for (int i = 0; i < 20 && slp; i++)
            step(1);
        {irq, rtc, two_wire_serial_interface, pin} = 4'h0;
        chk(8'({slp, cpu}), 8'h01);
        step(3);
    endtask
    task automatic t_modes();
        logic [2:0] m [5] = '{SPMC_IDLE, SPMC_PDOWN, SPMC_PSAVE,
            SPMC_STDBY, SPMC_ESTDBY};
        logic [2:0] osc [5] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h5};
        logic [3:0] src [5] = '{4'h8, 4'h1, 4'h4, 4'h1, 4'h4};
        logic [7:0] g;
        for (int i = 0; i < 5; i++)
        begin
            sleep(m[i]);
            g = 8'({cpu, mosc, xtal, rtce});
            chk(g, 8'(osc[i]));
            chk(8'(amode), 8'(m[i]));
            if (i < 2)
                chk(pen, i == 0 ? pon : 8'h00);
            wake(src[i]);
        end
        $display("modes done");
    endtask
    task automatic t_bad();
        logic [2:0] bad [3] = '{3'h1, 3'h4, 3'h5};
        foreach (bad[i])
        begin
            sleep(bad[i]);
            chk(8'({err, slp}), 8'h02);
        end
        sleep(SPMC_IDLE);
        chk(8'({err, slp}), 8'h01);
        wake(4'h8);
        $display("bad codes done");
    endtask
    task automatic t_periph();
        pon = 8'hA5;
        step(2);
        chk(pen, 8'hA5);
        sleep(SPMC_IDLE);
        pon = 8'h3C;
        step(2);
        chk(pen, 8'h3C);
        wake(4'h8);
        pon = 8'hFF;
        $display("peripheral gating done");
    endtask
    task automatic t_deep();
        sleep(SPMC_PDOWN);
        {irq, rtc} = 2'h3;
        req = 1;
        mode = SPMC_IDLE;
        step(1);
        req = 0;
        step(8);
        chk(8'({slp, amode}), 8'h0A);
        {irq, rtc} = 2'h0;
        wake(4'h2);
        $display("power-down wake done");
    endtask
    initial
    begin
        step(3);
        rst_n = 1;
        t_modes();
        t_bad();
        t_periph();
        t_deep();
        test_done();
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            test_done();
        end
    end
endmodule
bind spmc_top spmc_props #(.NUM_PERIPH(NUM_PERIPH)) u_props (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SLEEP_REQ(SLEEP_REQ),
    .SLEEP_MODE(SLEEP_MODE), .PERIPH_ON(PERIPH_ON),
    .PIN_CHANGE_WAKE(PIN_CHANGE_WAKE), .CPU_CLK_EN(CPU_CLK_EN),
    .MAIN_OSC_EN(MAIN_OSC_EN), .XTAL_EN(XTAL_EN), .RTC_EN(RTC_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .SLEEPING(SLEEPING),
    .ACTIVE_MODE(ACTIVE_MODE), .MODE_ERR(MODE_ERR));
`default_nettype wire
